// ==== core/rsp_core.sv ====
// Return stack, fast shadows, table regs and four-phase pipeline
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module rsp_core
    import rsp_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Avalon-MM slave
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Decoder, interrupt and memories
    input wire logic i_exec_valid,
    input wire rsp_exec_t i_exec,
    input wire logic i_irq_vector,
    input wire logic i_irq_high,
    input wire logic i_stack_error_reset_enable,
    input wire logic [15:0] i_prog_word,
    input wire logic [7:0] i_table_rdata,
    // Outputs
    output logic [20:0] o_pc,
    output logic [15:0] o_instruction_register,
    output logic [1:0] o_phase,
    output logic o_data_read,
    output logic o_data_write,
    output logic o_table_strobe,
    output logic o_device_reset
);
    rsp_phase_t phase_reg;
    logic [20:0] pc_reg;
    logic [15:0] fetch_reg;
    logic [15:0] ireg_reg;
    logic flush_reg;
    logic full_reg, unf_reg;
    logic [4:0] ptr_reg;
    logic [20:0] stack_mem [1:31];
    logic [7:0] status_reg, work_reg, counter_high_latch_reg, counter_upper_latch_reg, table_data_latch_reg;
    logic [3:0] bank_reg;
    logic [21:0] table_byte_pointer_reg;
    rsp_shadow_t shadow_reg;
    logic cfg_reg;
    logic [31:0] rdata_reg;
    logic wait_reg, dreset_reg, drd_reg, dwr_reg, tstr_reg;
    logic exec_now, wr_now, push_now, pop_now, redirect;
    logic [20:0] pc_next;
    logic stk_full_ev, stk_unf_ev;
    logic [7:0] pcl_sum;

    // Bus accepted on the second cycle: simple one-wait slave
    assign wr_now = i_write && wait_reg == 1'b0;
    assign exec_now = i_exec_valid && phase_reg == RSP_Q4 && !flush_reg;
    assign push_now = exec_now && (i_exec.op == RSP_OP_CALL ||
        i_exec.op == RSP_OP_PUSH) || i_irq_vector && phase_reg == RSP_Q4;
    assign pop_now = exec_now && (i_exec.op == RSP_OP_RET ||
        i_exec.op == RSP_OP_RETURN_FROM_INTERRUPT || i_exec.op == RSP_OP_POP);
    assign stk_full_ev = push_now && ptr_reg >= RSP_DEPTH - 5'h01;
    assign stk_unf_ev = pop_now && ptr_reg == RSP_PTR_ZERO;
    assign pcl_sum = pc_reg[7:0] + work_reg;

    // Next program counter
    always_comb begin
        pc_next = pc_reg + RSP_PC_STEP;
        redirect = 1'b0;
        if (i_irq_vector && phase_reg == RSP_Q4) begin
            pc_next = i_irq_high ? RSP_VEC_HIGH : RSP_VEC_LOW;
            redirect = 1'b1;
        end else if (exec_now) begin
            case (i_exec.op)
                RSP_OP_CALL, RSP_OP_GOTO: begin
                    pc_next = i_exec.target;
                    redirect = 1'b1;
                end
                RSP_OP_RET, RSP_OP_RETURN_FROM_INTERRUPT: begin
                    pc_next = stk_unf_ev ? RSP_PC_RESET
                        : stack_mem[ptr_reg];
                    redirect = 1'b1;
                end
                RSP_OP_ADDPCL: begin
                    pc_next = {counter_upper_latch_reg[4:0], counter_high_latch_reg,
                        pcl_sum[7:1], 1'b0};
                    redirect = 1'b1;
                end
                default: pc_next = pc_reg + RSP_PC_STEP;
            endcase
        end else if (wr_now && i_address == RSP_ADDR_PCL) begin
            pc_next = {counter_upper_latch_reg[4:0], counter_high_latch_reg,
                i_writedata[7:1], 1'b0};
            redirect = 1'b1;
        end
    end

    // Phase divider
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_reg <= RSP_Q1;
        end else begin
            case (phase_reg)
                RSP_Q1: phase_reg <= RSP_Q2;
                RSP_Q2: phase_reg <= RSP_Q3;
                RSP_Q3: phase_reg <= RSP_Q4;
                default: phase_reg <= RSP_Q1;
            endcase
        end
    end

    // Fetch, pipeline and flush
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pc_reg <= RSP_PC_RESET;
            fetch_reg <= RSP_NOP_WORD;
            ireg_reg <= RSP_NOP_WORD;
            flush_reg <= 1'b1;
        end else begin
            if (phase_reg == RSP_Q4) begin
                fetch_reg <= i_prog_word;
                if (redirect) begin
                    pc_reg <= pc_next;
                    flush_reg <= 1'b1;
                end else begin
                    flush_reg <= 1'b0;
                end
            end else if (wr_now && i_address == RSP_ADDR_PCL) begin
                pc_reg <= pc_next;
                flush_reg <= 1'b1;
            end
            if (phase_reg == RSP_Q1) begin
                ireg_reg <= flush_reg ? RSP_NOP_WORD : fetch_reg;
                if (!flush_reg) begin
                    pc_reg <= pc_reg + RSP_PC_STEP;
                end
            end
        end
    end

    // Data memory strobes
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            drd_reg <= 1'b0;
            dwr_reg <= 1'b0;
        end else begin
            drd_reg <= phase_reg == RSP_Q1;
            dwr_reg <= phase_reg == RSP_Q3;
        end
    end

    // Return stack and error reset
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ptr_reg <= RSP_PTR_ZERO;
            full_reg <= 1'b0;
            unf_reg <= 1'b0;
            dreset_reg <= 1'b0;
        end else begin
            dreset_reg <= 1'b0;
            if (wr_now && i_address == RSP_ADDR_STKREG) begin
                ptr_reg <= i_writedata[4:0];
                if (!i_writedata[RSP_FULL_BIT]) full_reg <= 1'b0;
                if (!i_writedata[RSP_UNF_BIT]) unf_reg <= 1'b0;
            end
            if (push_now) begin
                if (ptr_reg != RSP_DEPTH) begin
                    ptr_reg <= ptr_reg + 5'h01;
                    stack_mem[ptr_reg + 5'h01] <= pc_reg;
                end
                if (stk_full_ev) begin
                    full_reg <= 1'b1;
                    dreset_reg <= cfg_reg;
                end
            end else if (pop_now) begin
                if (stk_unf_ev) begin
                    unf_reg <= 1'b1;
                    dreset_reg <= cfg_reg;
                end else begin
                    ptr_reg <= ptr_reg - 5'h01;
                end
            end
            if (dreset_reg) ptr_reg <= RSP_PTR_ZERO;
        end
    end

    // Shadows and core registers
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shadow_reg <= '0;
            status_reg <= 8'h00;
            work_reg <= 8'h00;
            bank_reg <= 4'h0;
            counter_high_latch_reg <= 8'h00;
            counter_upper_latch_reg <= 8'h00;
        end else begin
            if (wr_now) begin
                case (i_address)
                    RSP_ADDR_WORK: work_reg <= i_writedata[7:0];
                    RSP_ADDR_STATUS: status_reg <= i_writedata[7:0];
                    RSP_ADDR_BANK: bank_reg <= i_writedata[3:0];
                    RSP_ADDR_COUNTER_HIGH_LATCH: counter_high_latch_reg <= i_writedata[7:0];
                    RSP_ADDR_COUNTER_UPPER_LATCH: counter_upper_latch_reg <= i_writedata[7:0];
                    default: ;
                endcase
            end
            // Last capture wins, so a nested high interrupt overwrites
            if ((i_irq_vector && phase_reg == RSP_Q4) || (exec_now &&
                    i_exec.op == RSP_OP_CALL && i_exec.fast)) begin
                shadow_reg <= {status_reg, work_reg, bank_reg};
            end else if (exec_now && i_exec.fast && (i_exec.op ==
                    RSP_OP_RET || i_exec.op == RSP_OP_RETURN_FROM_INTERRUPT)) begin
                status_reg <= shadow_reg.status;
                work_reg <= shadow_reg.work;
                bank_reg <= shadow_reg.bank;
            end
        end
    end

    // Table pointer and latch
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            table_byte_pointer_reg <= 22'h000000;
            table_data_latch_reg <= 8'h00;
            tstr_reg <= 1'b0;
            cfg_reg <= 1'b1;
        end else begin
            tstr_reg <= 1'b0;
            if (wr_now && i_address == RSP_ADDR_TABLE_BYTE_POINTER)
                table_byte_pointer_reg <= i_writedata[21:0];
            if (wr_now && i_address == RSP_ADDR_TABLE_DATA_LATCH)
                table_data_latch_reg <= i_writedata[7:0];
            if (wr_now && i_address == RSP_ADDR_CONFIG)
                cfg_reg <= i_writedata[0];
            if (i_read && !wait_reg && i_address == RSP_ADDR_TABLE_DATA_LATCH) begin
                table_data_latch_reg <= i_table_rdata;
                tstr_reg <= 1'b1;
            end
        end
    end

    // Bus slave: one wait state, then answer
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= RSP_UNMAPPED;
        end else begin
            wait_reg <= !((i_read || i_write) && wait_reg);
            case (i_address)
                RSP_ADDR_STKREG: rdata_reg <= {24'h0, full_reg, unf_reg,
                    1'b0, ptr_reg};
                RSP_ADDR_WORK: rdata_reg <= {24'h0, work_reg};
                RSP_ADDR_STATUS: rdata_reg <= {24'h0, status_reg};
                RSP_ADDR_BANK: rdata_reg <= {28'h0, bank_reg};
                RSP_ADDR_PCL: rdata_reg <= {24'h0, pc_reg[7:0]};
                RSP_ADDR_COUNTER_HIGH_LATCH: rdata_reg <= {24'h0, counter_high_latch_reg};
                RSP_ADDR_COUNTER_UPPER_LATCH: rdata_reg <= {24'h0, counter_upper_latch_reg};
                RSP_ADDR_TABLE_BYTE_POINTER: rdata_reg <= {10'h0, table_byte_pointer_reg};
                RSP_ADDR_TABLE_DATA_LATCH: rdata_reg <= {24'h0, table_data_latch_reg};
                RSP_ADDR_CONFIG: rdata_reg <= {31'h0, cfg_reg};
                RSP_ADDR_PC: rdata_reg <= {11'h0, pc_reg};
                RSP_ADDR_IREG: rdata_reg <= {16'h0, ireg_reg};
                default: rdata_reg <= RSP_UNMAPPED;
            endcase
        end
    end

    assign o_readdata = rdata_reg;
    assign o_waitrequest = wait_reg;
    assign o_pc = pc_reg;
    assign o_instruction_register = ireg_reg;
    assign o_phase = phase_reg;
    assign o_data_read = drd_reg;
    assign o_data_write = dwr_reg;
    assign o_table_strobe = tstr_reg;
    assign o_device_reset = dreset_reg;

    // Checks
    phase_cycle_a: assert property (@(posedge i_mclk) disable iff
        (!i_reset_n) phase_reg == RSP_Q4 |=> phase_reg == RSP_Q1)
        else $error("phase order broken");
    bit_five_zero_a: assert property (@(posedge i_mclk) disable iff
        (!i_reset_n) rdata_reg[5] == 1'b0 || i_address != RSP_ADDR_STKREG
        || $past(i_address) != RSP_ADDR_STKREG)
        else $error("stack bit five set");
    full_set_a: assert property (@(posedge i_mclk) disable iff
        (!i_reset_n) stk_full_ev |=> full_reg)
        else $error("full flag not set");
    unf_set_a: assert property (@(posedge i_mclk) disable iff
        (!i_reset_n) stk_unf_ev |=> unf_reg && ptr_reg == RSP_PTR_ZERO)
        else $error("underflow not flagged");
    flag_no_set_a: assert property (@(posedge i_mclk) disable iff
        (!i_reset_n) !full_reg && !push_now |=> !full_reg)
        else $error("full flag set by software");
    err_reset_a: assert property (@(posedge i_mclk) disable iff
        (!i_reset_n) (stk_full_ev || stk_unf_ev) |=> dreset_reg == cfg_reg)
        else $error("error reset mismatch");
    no_reset_a: assert property (@(posedge i_mclk) disable iff
        (!i_reset_n) !cfg_reg ##1 !cfg_reg |-> !dreset_reg)
        else $error("reset while disabled");
    pc_even_a: assert property (@(posedge i_mclk) disable iff
        (!i_reset_n) pc_reg[0] == 1'b0)
        else $error("pc odd");
    strobe_phase_a: assert property (@(posedge i_mclk) disable iff
        (!i_reset_n) drd_reg |-> phase_reg == RSP_Q2)
        else $error("read strobe out of phase");
endmodule : rsp_core

// ==== core/rsp_pkg.sv ====
// Package: constants and types for the return stack and pipeline block
package rsp_pkg;
    // Register map (word offsets on the Avalon bus, byte address = 4*index)
    localparam logic [3:0] RSP_ADDR_STKREG = 4'h0;
    localparam logic [3:0] RSP_ADDR_WORK = 4'h1;
    localparam logic [3:0] RSP_ADDR_STATUS = 4'h2;
    localparam logic [3:0] RSP_ADDR_BANK = 4'h3;
    localparam logic [3:0] RSP_ADDR_PCL = 4'h4;
    localparam logic [3:0] RSP_ADDR_COUNTER_HIGH_LATCH = 4'h5;
    localparam logic [3:0] RSP_ADDR_COUNTER_UPPER_LATCH = 4'h6;
    localparam logic [3:0] RSP_ADDR_TABLE_BYTE_POINTER = 4'h7;
    localparam logic [3:0] RSP_ADDR_TABLE_DATA_LATCH = 4'h8;
    localparam logic [3:0] RSP_ADDR_CONFIG = 4'h9;
    localparam logic [3:0] RSP_ADDR_PC = 4'ha;
    localparam logic [3:0] RSP_ADDR_IREG = 4'hb;
    // Field positions of the stack pointer register, then depth, reset values and other constants
    localparam int RSP_FULL_BIT = 7;
    localparam int RSP_UNF_BIT = 6;
    localparam logic [4:0] RSP_DEPTH = 5'h1f;
    localparam logic [4:0] RSP_PTR_ZERO = 5'h00;
    localparam logic [7:0] RSP_STK_RESET = 8'h00;
    localparam logic [20:0] RSP_PC_RESET = 21'h000000;
    localparam logic [20:0] RSP_PC_STEP = 21'h000002;
    localparam logic [20:0] RSP_VEC_HIGH = 21'h000008;
    localparam logic [20:0] RSP_VEC_LOW = 21'h000018;
    localparam logic [15:0] RSP_NOP_WORD = 16'h0000;
    localparam logic [3:0] RSP_BANK_MASK = 4'hf;
    localparam logic [31:0] RSP_UNMAPPED = 32'h00000000;
    // Instruction cycle phases
    typedef enum logic [1:0] {RSP_Q1, RSP_Q2, RSP_Q3, RSP_Q4} rsp_phase_t;
    // Operation requested by the instruction decoder for the execute cycle
    typedef enum logic [2:0] {
        RSP_OP_NONE, RSP_OP_CALL, RSP_OP_RET, RSP_OP_RETURN_FROM_INTERRUPT, RSP_OP_GOTO,
        RSP_OP_PUSH, RSP_OP_POP, RSP_OP_ADDPCL
    } rsp_op_t;
    // Execute request from the decoder
    typedef struct packed {
        rsp_op_t op;
        logic fast;
        logic [20:0] target;
    } rsp_exec_t;
    // Fast shadow set
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] work;
        logic [3:0] bank;
    } rsp_shadow_t;
endpackage : rsp_pkg

// ==== bench/rsp_prog_mem.sv ====
// Program memory model feeding fetch words and table bytes
`timescale 1ns/1ps
module rsp_prog_mem #(
    parameter logic [7:0] TABLE_BYTE = 8'h3c
) (
    // Fetch address
    input wire logic [20:0] i_pc,
    // Returned data
    output logic [15:0] o_word,
    output logic [7:0] o_table_byte
);
    // Word depends on page only, so fetch offset timing cannot skew it
    assign o_word = {i_pc[15:8], 8'h5a};
    assign o_table_byte = TABLE_BYTE;
endmodule : rsp_prog_mem

// ==== bench/return_stack_and_pipeline_bench.sv ====
// Self-checking bench for the return stack and pipeline core
`timescale 1ns/1ps
module return_stack_and_pipeline_bench
    import rsp_pkg::*;
;
    typedef struct {logic [3:0] a; logic [31:0] w; logic [31:0] e;} rsp_row_t;
    logic mclk, rst_n, rd, wr, ev, irq, irq_hi, wrq, dres, tstb, d_rd, d_wr;
    logic [3:0] adr;
    logic [31:0] wd, rdata, q;
    rsp_exec_t exq;
    logic [15:0] word, ir, ir_q;
    logic [7:0] tbyte;
    logic [20:0] pc;
    logic [1:0] ph, ph_q;
    logic seen_rst, seen_stb, run;
    logic [15:0] hist[$];
    int n_mismatch, comparisons;
    rsp_row_t rows[8];

    rsp_core dut (.i_mclk(mclk), .i_reset_n(rst_n), .i_address(adr),
        .i_read(rd), .i_write(wr), .i_writedata(wd), .o_readdata(rdata),
        .o_waitrequest(wrq), .i_exec_valid(ev), .i_exec(exq),
        .i_irq_vector(irq), .i_irq_high(irq_hi),
        .i_stack_error_reset_enable(1'b0), .i_prog_word(word),
        .i_table_rdata(tbyte), .o_pc(pc), .o_instruction_register(ir),
        .o_phase(ph), .o_data_read(d_rd), .o_data_write(d_wr),
        .o_table_strobe(tstb), .o_device_reset(dres));
    rsp_prog_mem mem (.i_pc(pc), .o_word(word), .o_table_byte(tbyte));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge mclk);
            n++;
        end while (wrq !== 1'b0 && n < 64);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 64) chk(32'h0, 32'h1);
    endtask : bus

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd_chk

    task automatic set3(input logic [7:0] w, s, b);
        bus(1'b1, 4'h1, {24'h0, w});
        bus(1'b1, 4'h2, {24'h0, s});
        bus(1'b1, 4'h3, {24'h0, b});
    endtask : set3

    task automatic chk3(input logic [7:0] w, s, b);
        rd_chk(4'h1, {24'h0, w});
        rd_chk(4'h2, {24'h0, s});
        rd_chk(4'h3, {24'h0, b});
    endtask : chk3

    // Decoder request is presented for the whole Q4 cycle only
    task automatic step(input rsp_op_t op, input logic f,
        input logic [20:0] t, input logic iq, input logic hi);
        do @(posedge mclk); while (ph !== 2'd2);
        ev <= (op != RSP_OP_NONE);
        exq <= '{op, f, t};
        irq <= iq;
        irq_hi <= hi;
        @(posedge mclk);
        ev <= 1'b0;
        irq <= 1'b0;
        hist.delete();
        repeat (8) @(posedge mclk);
    endtask : step

    always @(posedge mclk) begin
        if (run) begin
            chk({30'h0, ph}, {30'h0, ph_q + 2'd1});
            if ((d_rd && ph !== 2'd1) || (d_wr && ph !== 2'd3)) chk(0, 1);
            // IR loads at the Q1 edge, so its new value shows with Q2
            if (ir !== ir_q && ph !== 2'd1) chk(0, 1);
            if (ph === 2'd1) hist.push_back(ir);
            if (dres === 1'b1) seen_rst = 1'b1;
            if (tstb === 1'b1) seen_stb = 1'b1;
        end
        ph_q <= ph;
        ir_q <= ir;
    end

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    initial begin
        #3000000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        {rst_n, rd, wr, ev, irq, irq_hi, run, seen_rst, seen_stb} = '0;
        adr = 4'h0;
        wd = 32'h0;
        exq = '{RSP_OP_NONE, 1'b0, 21'h0};
        rows = '{'{4'h1, 32'ha5, 32'ha5}, '{4'h2, 32'h3c, 32'h3c},
            '{4'h3, 32'hff, 32'h0f}, '{4'h5, 32'h12, 32'h12},
            '{4'h6, 32'h01, 32'h01}, '{4'h7, 32'h2a, 32'h2a},
            '{4'h0, 32'hff, 32'h1f}, '{4'hc, 32'h55, 32'h00}};
        repeat (8) @(posedge mclk);
        chk({31'h0, wrq}, 32'h1);
        chk({11'h0, pc}, 32'h0);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        run = 1'b1;
        rd_chk(4'h0, 32'h0);
        rd_chk(4'h9, 32'h1);
        $display("test reset done");
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].w);
            rd_chk(rows[i].a, rows[i].e);
        end
        // First read loads the latch; data shows on the next read
        bus(1'b0, 4'h8, 32'h0);
        rd_chk(4'h8, 32'h3c);
        chk({31'h0, seen_stb}, 32'h1);
        $display("test registers done");
        bus(1'b1, 4'h9, 32'h0);
        bus(1'b1, 4'h0, 32'h0);
        seen_rst = 1'b0;
        for (int i = 0; i < 30; i++) step(RSP_OP_PUSH, 1'b0, 21'h0, 0, 0);
        rd_chk(4'h0, 32'h1e);
        step(RSP_OP_PUSH, 1'b0, 21'h0, 0, 0);
        chk({24'h0, hist[0][7:0]}, 32'h5a);
        rd_chk(4'h0, 32'h9f);
        bus(1'b1, 4'h0, 32'h1f);
        rd_chk(4'h0, 32'h1f);
        for (int i = 0; i < 31; i++) step(RSP_OP_RET, 1'b0, 21'h0, 0, 0);
        rd_chk(4'h0, 32'h0);
        step(RSP_OP_RET, 1'b0, 21'h0, 0, 0);
        rd_chk(4'h0, 32'h40);
        chk({31'h0, pc < 21'h10}, 32'h1);
        chk({31'h0, seen_rst}, 32'h0);
        bus(1'b1, 4'h9, 32'h1);
        bus(1'b1, 4'h0, 32'h0);
        seen_rst = 1'b0;
        step(RSP_OP_RET, 1'b0, 21'h0, 0, 0);
        chk({31'h0, seen_rst}, 32'h1);
        rd_chk(4'h0, 32'h40);
        $display("test stack done");
        set3(8'h11, 8'h22, 8'h03);
        step(RSP_OP_NONE, 1'b0, 21'h0, 1, 0);
        set3(8'h44, 8'h55, 8'h06);
        step(RSP_OP_NONE, 1'b0, 21'h0, 1, 1);
        set3(8'h77, 8'h66, 8'h09);
        step(RSP_OP_RETURN_FROM_INTERRUPT, 1'b1, 21'h0, 0, 0);
        chk3(8'h44, 8'h55, 8'h06);
        set3(8'h21, 8'h32, 8'h04);
        step(RSP_OP_CALL, 1'b1, 21'h200, 0, 0);
        set3(8'h00, 8'h00, 8'h00);
        step(RSP_OP_RET, 1'b1, 21'h0, 0, 0);
        chk3(8'h21, 8'h32, 8'h04);
        $display("test shadows done");
        step(RSP_OP_GOTO, 1'b0, 21'h100, 0, 0);
        chk({16'h0, hist[0]}, {16'h0, RSP_NOP_WORD});
        chk({16'h0, hist[1]}, 32'h015a);
        chk({19'h0, pc[20:8]}, 32'h001);
        bus(1'b1, 4'h1, 32'h4);
        step(RSP_OP_ADDPCL, 1'b0, 21'h0, 0, 0);
        chk({16'h0, hist[0]}, {16'h0, RSP_NOP_WORD});
        chk({19'h0, pc[20:8]}, 32'h112);
        $display("test pipeline done");
        tally_and_finish();
    end
endmodule : return_stack_and_pipeline_bench
